// [src/pll_ctrl_pkg.sv]
// constants for the clock multiplier and power mode control block
// assumes one 250 MHz clock and register accesses already decoded from the serial port
package pll_ctrl_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// register offsets
	localparam logic [7:0] OFFS_CHANNEL_INDEX_SELECT   = 8'h05;
	localparam logic [7:0] OFFS_POWER_MODE_SELECT      = 8'h08;
	localparam logic [7:0] OFFS_MULTIPLIER_ENABLE_CTRL = 8'h09;
	localparam logic [7:0] OFFS_MULTIPLIER_FACTOR_LOCK = 8'h0a;

	// field positions
	localparam int CHAN_INDEX_LSB  = 0;
	localparam int CHAN_INDEX_W    = 2;
	localparam int POWER_MODE_LSB  = 0;
	localparam int POWER_MODE_W    = 2;
	localparam int ENABLE_BIT      = 2;
	localparam int FACTOR_LSB      = 0;
	localparam int FACTOR_W        = 6;
	localparam int AUTOBAND_BIT    = 6;
	localparam int LOCK_BIT        = 7;
	localparam int STRAP_W         = 5;
	localparam int N_W             = 6;

	// reset values
	localparam logic [1:0] CHAN_INDEX_RESET = 2'h3;
	localparam logic [1:0] POWER_MODE_RESET = 2'h0;
	localparam logic       ENABLE_RESET     = 1'b0;
	localparam logic [5:0] FACTOR_RESET     = 6'h00;
	localparam logic       AUTOBAND_RESET   = 1'b0;

	// strap code that selects direct clocking
	localparam logic [4:0] STRAP_DIRECT = 5'h1f;

	// timing
	localparam int CLK_PERIOD_PS     = 4000;
	localparam int BAND_CAL_TIME_NS  = 2000;
	localparam int LOCK_QUAL_TIME_NS = 1000;
	localparam int BAND_CAL_CYCLES   = (BAND_CAL_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int LOCK_QUAL_CYCLES  = (LOCK_QUAL_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	typedef enum logic [1:0] {
		PWR_NORMAL    = 2'b00,
		PWR_CHAN_DOWN = 2'b01,
		PWR_STANDBY   = 2'b10,
		PWR_SLEEP     = 2'b11
	} power_mode_t;

	typedef enum logic [1:0] {
		LOOP_IDLE     = 2'b00,
		LOOP_BAND_CAL = 2'b01,
		LOOP_ACQUIRE  = 2'b10,
		LOOP_LOCKED   = 2'b11
	} loop_state_t;

endpackage

// [src/mult_factor_decode.sv]
// multiplication factor decoder for the register field and the strap pins
// assumes a purely combinational use; the caller registers the result
`timescale 1ns/1ps
`default_nettype none
module mult_factor_decode
	import pll_ctrl_pkg::*;
(
	input  wire logic [5:0] regCode,
	input  wire logic [4:0] strapCode,
	input  wire logic       useStraps,
	output logic [5:0]      factorN,
	output logic            strapBypass
);

	logic [5:0] regN;
	logic [5:0] strapN;

	always_comb begin
		if (regCode <= 6'd8)
			regN = 6'd8; // RL12
		else if (regCode <= 6'd9)
			regN = 6'd9;
		else if (regCode <= 6'd11)
			regN = 6'd10;
		else if (regCode <= 6'd13)
			regN = 6'd12;
		else if (regCode <= 6'd17)
			regN = regCode;
		else if (regCode <= 6'd19)
			regN = 6'd18;
		else if (regCode <= 6'd20)
			regN = 6'd20;
		else if (regCode <= 6'd23)
			regN = 6'd21;
		else if (regCode == 6'd24)
			regN = 6'd24; // RL13
		else if (regCode <= 6'd27)
			regN = 6'd25;
		else if (regCode <= 6'd29)
			regN = 6'd28;
		else if (regCode <= 6'd31)
			regN = 6'd30;
		else if (regCode <= 6'd33)
			regN = 6'd32;
		else if (regCode <= 6'd41)
			regN = 6'd34;
		else
			regN = 6'd42;
	end

	always_comb begin
		unique case (strapCode) // RL11
			5'd0:    strapN = 6'd8;
			5'd1:    strapN = 6'd9;
			5'd2:    strapN = 6'd10;
			5'd3:    strapN = 6'd12;
			5'd4:    strapN = 6'd14;
			5'd5:    strapN = 6'd15;
			5'd6:    strapN = 6'd16;
			5'd7:    strapN = 6'd17;
			5'd8:    strapN = 6'd18;
			5'd9:    strapN = 6'd20;
			5'd10:   strapN = 6'd21;
			5'd11:   strapN = 6'd24;
			5'd12:   strapN = 6'd25;
			5'd13:   strapN = 6'd28;
			5'd14:   strapN = 6'd30;
			5'd15:   strapN = 6'd32;
			5'd16:   strapN = 6'd34;
			default: strapN = 6'd42;
		endcase
	end

	always_comb begin
		factorN     = useStraps ? strapN : regN;
		strapBypass = useStraps && (strapCode == STRAP_DIRECT); // RL10
	end

endmodule
`default_nettype wire

// [src/pll_multiplier_power_mode_ctrl.sv]
// control of the on-chip clock multiplier and the low power modes
// assumes register accesses arrive already decoded from the serial port, one per cycle,
// and that the analog loop reports its raw lock detect synchronously to clk
//
// Operation
// [RL1] oscillator runs at reference times N; modulator clock is oscillator halved, 50% duty
// [RL2] host supplies a 30 to 160 MHz reference while the multiplier is used
// [RL3] serial control takes multiplier setup from the enable and factor registers
// [RL4] host writes the six-bit factor before setting the enable bit
// [RL5] after enable and lock, the locked state shows in factor register bit 7
// [RL6] host clears and sets enable again after changing the factor
// [RL7] host order: reference, then factor, then enable by writing four
// [RL8] serial interface stays inactive after power-up until the first serial access
// [RL9] while serial is inactive the factor comes from the five strap pins
// [RL10] strap value 31 disables the multiplier and clocks directly from the inputs
// [RL11] strap value decodes to N by the fixed strap table
// [RL12] register factor lower codes decode to N by the fixed table
// [RL13] register factor upper codes decode to N, 42 and above giving 42
// [RL14] band-select bit makes the device pick the oscillator band automatically
// [RL15] power mode: normal, analog off, analog and clock off, everything off
// [RL16] standby stops clocks, powers down channels, keeps references and output drivers
// [RL17] sleep powers down everything and disables the output drivers
// [RL18] channel index selects which channels later power mode writes reach
// [RL19] without serial control a high power-down pin powers down its channel
// [RL20] out of reset the multiplier is bypassed and clocking is direct; the code does so only for strap 31 until the first serial access
// [RL21] lock bit reads zero while disabled and while reacquiring after re-enable
`timescale 1ns/1ps
`default_nettype none
module pll_multiplier_power_mode_ctrl
	import pll_ctrl_pkg::*;
#(
	parameter int BAND_CAL_CNT  = BAND_CAL_CYCLES,
	parameter int LOCK_QUAL_CNT = LOCK_QUAL_CYCLES
)(
	input  wire logic              clk,
	input  wire logic              reset_n,
	input  wire logic              clkEn,
	input  wire logic              regWrite,
	input  wire logic              regRead,
	input  wire logic [ADDR_W-1:0] regAddr,
	input  wire logic [DATA_W-1:0] regWrData,
	output logic      [DATA_W-1:0] regRdData,
	input  wire logic [STRAP_W-1:0] factorStrapPins,
	input  wire logic              chanAPowerdownPin,
	input  wire logic              chanBPowerdownPin,
	input  wire logic              loopLockIn,
	output logic      [N_W-1:0]    multFactor,
	output logic                   multiplierOn,
	output logic                   directClock,
	output logic                   autoBandSelect,
	output logic                   bandCalRun,
	output logic                   lockedOut,
	output logic                   serialActive,
	output logic                   modulatorClock,
	output logic      [1:0]        chanPowerDown,
	output logic                   clockPowerDown,
	output logic                   refPowerDown,
	output logic                   lvdsDriverOff
);

	localparam int CNT_W = 16;

	generate
		if (BAND_CAL_CNT < 1 || BAND_CAL_CNT >= (1 << CNT_W))
			$error("BAND_CAL_CNT out of range");
		if (LOCK_QUAL_CNT < 1 || LOCK_QUAL_CNT >= (1 << CNT_W))
			$error("LOCK_QUAL_CNT out of range");
	endgenerate

	// reset release through two flops
	logic resetMeta;
	logic resetSync;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			resetMeta <= 1'b0;
			resetSync <= 1'b0;
		end else begin
			resetMeta <= 1'b1;
			resetSync <= resetMeta;
		end
	end

	wire logic rstN = resetSync;

	// register state
	logic [CHAN_INDEX_W-1:0] chanIndex;
	power_mode_t             powerMode [2];
	logic                    multiplierEnableBit;
	logic [FACTOR_W-1:0]     factorCode;
	logic                    autoBandBit;
	logic                    lockBit;

	wire logic wrChanIndex = regWrite && (regAddr == OFFS_CHANNEL_INDEX_SELECT);
	wire logic wrPowerMode = regWrite && (regAddr == OFFS_POWER_MODE_SELECT);
	wire logic wrEnable    = regWrite && (regAddr == OFFS_MULTIPLIER_ENABLE_CTRL);
	wire logic wrFactor    = regWrite && (regAddr == OFFS_MULTIPLIER_FACTOR_LOCK);

	// any access wakes the serial interface for good
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN)
			serialActive <= 1'b0;
		else if (clkEn && (regWrite || regRead))
			serialActive <= 1'b1; // RL8
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN)
			chanIndex <= CHAN_INDEX_RESET;
		else if (clkEn && wrChanIndex)
			chanIndex <= regWrData[CHAN_INDEX_LSB +: CHAN_INDEX_W]; // RL18
	end

	// a power mode write reaches every channel whose index bit is set
	generate
		for (genvar c = 0; c < 2; c++) begin : g_mode
			always_ff @(posedge clk or negedge rstN) begin
				if (!rstN)
					powerMode[c] <= power_mode_t'(POWER_MODE_RESET);
				else if (clkEn && wrPowerMode && chanIndex[c])
					powerMode[c] <= power_mode_t'(regWrData[POWER_MODE_LSB +: POWER_MODE_W]); // RL18
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN)
			multiplierEnableBit <= ENABLE_RESET; // RL20
		else if (clkEn && wrEnable)
			multiplierEnableBit <= regWrData[ENABLE_BIT]; // RL3
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			factorCode  <= FACTOR_RESET;
			autoBandBit <= AUTOBAND_RESET;
		end else if (clkEn && wrFactor) begin
			factorCode  <= regWrData[FACTOR_LSB +: FACTOR_W]; // RL3
			autoBandBit <= regWrData[AUTOBAND_BIT]; // RL14
		end
	end

	// factor decode, straps until the first serial access
	logic [N_W-1:0] decodedN;
	logic           strapBypass;

	mult_factor_decode u_decode (
		.regCode     (factorCode),
		.strapCode   (factorStrapPins),
		.useStraps   (!serialActive), // RL9
		.factorN     (decodedN),
		.strapBypass (strapBypass)
	);

	// the multiplier runs when enabled by register, or by straps other than 31
	wire logic wantMultiplier = serialActive ? multiplierEnableBit : !strapBypass; // RL10 RL20

	// clocks stop in standby and sleep on either channel
	logic clocksStopped;
	logic everythingOff;

	always_comb begin
		clocksStopped = (powerMode[0] == PWR_STANDBY) || (powerMode[0] == PWR_SLEEP) ||
		                (powerMode[1] == PWR_STANDBY) || (powerMode[1] == PWR_SLEEP);
		everythingOff = (powerMode[0] == PWR_SLEEP) || (powerMode[1] == PWR_SLEEP);
	end

	// loop control: band calibration, acquisition, qualified lock
	loop_state_t    loopState;
	loop_state_t    next_loopState;
	logic [CNT_W-1:0] loopCount;
	logic [N_W-1:0] lockedN;
	logic           restartLoop;

	// a new factor or a stopped clock forces a fresh acquisition
	always_comb begin
		restartLoop = (decodedN != lockedN) || clocksStopped;
	end

	always_comb begin
		next_loopState = loopState;
		unique case (loopState)
			LOOP_IDLE: begin
				if (wantMultiplier && !clocksStopped)
					next_loopState = autoBandBit ? LOOP_BAND_CAL : LOOP_ACQUIRE; // RL14
			end
			LOOP_BAND_CAL: begin
				if (!wantMultiplier || clocksStopped)
					next_loopState = LOOP_IDLE;
				else if (!autoBandBit || loopCount == CNT_W'(BAND_CAL_CNT - 1))
					next_loopState = LOOP_ACQUIRE;
			end
			LOOP_ACQUIRE: begin
				if (!wantMultiplier || clocksStopped)
					next_loopState = LOOP_IDLE;
				else if (loopLockIn && loopCount == CNT_W'(LOCK_QUAL_CNT - 1))
					next_loopState = LOOP_LOCKED; // RL5
			end
			LOOP_LOCKED: begin
				if (!wantMultiplier || clocksStopped)
					next_loopState = LOOP_IDLE; // RL21
				else if (restartLoop || !loopLockIn)
					next_loopState = LOOP_ACQUIRE; // RL21
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN)
			loopState <= LOOP_IDLE;
		else if (clkEn)
			loopState <= next_loopState;
	end

	// counter restarts on each state change and on a lost lock detect
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN)
			loopCount <= '0;
		else if (clkEn) begin
			if (next_loopState != loopState || (loopState == LOOP_ACQUIRE && !loopLockIn))
				loopCount <= '0;
			else if (loopState == LOOP_BAND_CAL || loopState == LOOP_ACQUIRE)
				loopCount <= loopCount + CNT_W'(1);
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN)
			lockedN <= '0;
		else if (clkEn && next_loopState == LOOP_LOCKED && loopState != LOOP_LOCKED)
			lockedN <= decodedN;
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN)
			lockBit <= 1'b0;
		else if (clkEn)
			lockBit <= (next_loopState == LOOP_LOCKED); // RL5 RL21
	end

	// multiplier side outputs
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			multFactor     <= '0;
			multiplierOn   <= 1'b0;
			directClock    <= 1'b1; // RL20
			autoBandSelect <= 1'b0;
			bandCalRun     <= 1'b0;
			lockedOut      <= 1'b0;
		end else if (clkEn) begin
			multFactor     <= decodedN; // RL1
			multiplierOn   <= wantMultiplier && !clocksStopped;
			directClock    <= !wantMultiplier; // RL10
			autoBandSelect <= autoBandBit; // RL14
			bandCalRun     <= (next_loopState == LOOP_BAND_CAL);
			lockedOut      <= (next_loopState == LOOP_LOCKED);
		end
	end

	// halving stage gives equal high and low times; held low while stopped
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN)
			modulatorClock <= 1'b0;
		else if (clkEn) begin
			if (clocksStopped || !(wantMultiplier && loopState == LOOP_LOCKED))
				modulatorClock <= 1'b0; // RL16
			else
				modulatorClock <= !modulatorClock; // RL1
		end
	end

	// power control outputs
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			chanPowerDown  <= 2'b00;
			clockPowerDown <= 1'b0;
			refPowerDown   <= 1'b0;
			lvdsDriverOff  <= 1'b0;
		end else if (clkEn) begin
			// pins act only while the serial interface is inactive
			chanPowerDown[0] <= (powerMode[0] != PWR_NORMAL) || clocksStopped ||
			                    (!serialActive && chanAPowerdownPin); // RL15 RL16 RL19
			chanPowerDown[1] <= (powerMode[1] != PWR_NORMAL) || clocksStopped ||
			                    (!serialActive && chanBPowerdownPin); // RL15 RL16 RL19
			clockPowerDown   <= clocksStopped; // RL15 RL16
			refPowerDown     <= everythingOff; // RL15 RL17
			lvdsDriverOff    <= everythingOff; // RL17
		end
	end

	// read data: index of the lowest selected channel picks the mode shown
	logic [DATA_W-1:0] readMux;

	always_comb begin
		readMux = '0;
		unique case (regAddr)
			OFFS_CHANNEL_INDEX_SELECT:
				readMux[CHAN_INDEX_LSB +: CHAN_INDEX_W] = chanIndex;
			OFFS_POWER_MODE_SELECT:
				readMux[POWER_MODE_LSB +: POWER_MODE_W] = chanIndex[0] ? powerMode[0] : powerMode[1];
			OFFS_MULTIPLIER_ENABLE_CTRL:
				readMux[ENABLE_BIT] = multiplierEnableBit;
			OFFS_MULTIPLIER_FACTOR_LOCK: begin
				readMux[FACTOR_LSB +: FACTOR_W] = factorCode;
				readMux[AUTOBAND_BIT]           = autoBandBit;
				readMux[LOCK_BIT]               = lockBit && multiplierEnableBit; // RL5 RL21
			end
			default:
				readMux = '0;
		endcase
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN)
			regRdData <= '0;
		else if (clkEn && regRead)
			regRdData <= readMux;
	end

endmodule
`default_nettype wire

// [sim/loop_lock_model.sv]
// analog loop stand-in: reports lock a fixed time after the loop starts running
// assumes run is high while the block drives the multiplier
`timescale 1ns/1ps
`default_nettype none
module loop_lock_model #(
	parameter int LOCK_DLY = 5
)(
	input  wire logic clk,
	input  wire logic run,
	output var logic  lockDetect = 1'b0
);
	int cnt = 0;
	// reference assumed inside its range; oscillator settles at ref times N
	always @(posedge clk) begin
		if (!run) begin
			cnt <= 0;
			lockDetect <= 1'b0;
		end else if (cnt == LOCK_DLY) begin
			lockDetect <= 1'b1;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule
`default_nettype wire

// [sim/pll_multiplier_power_mode_ctrl_properties.sv]
// port checker for the multiplier and power mode block
// assumes the top module ports only
`timescale 1ns/1ps
`default_nettype none
module pll_ctrl_properties
	import pll_ctrl_pkg::*;
(
	input wire logic              clk,
	input wire logic              reset_n,
	input wire logic              clkEn,
	input wire logic              regWrite,
	input wire logic              regRead,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [DATA_W-1:0] regRdData,
	input wire logic [STRAP_W-1:0] factorStrapPins,
	input wire logic              chanAPowerdownPin,
	input wire logic              loopLockIn,
	input wire logic [N_W-1:0]    multFactor,
	input wire logic              multiplierOn,
	input wire logic              directClock,
	input wire logic              autoBandSelect,
	input wire logic              bandCalRun,
	input wire logic              lockedOut,
	input wire logic              serialActive,
	input wire logic              modulatorClock,
	input wire logic [1:0]        chanPowerDown,
	input wire logic              clockPowerDown,
	input wire logic              refPowerDown,
	input wire logic              lvdsDriverOff
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic [1:0] up;
	logic       ok;
	logic       pinMode;
	// internal reset lifts two edges after release
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) up <= 2'h0;
		else if (up != 2'h3) up <= up + 2'h1;
	end
	assign ok = (up == 2'h3);
	assign pinMode = ok && clkEn && !serialActive && !regWrite && !regRead;

	property p_direct; multiplierOn |-> !directClock; endproperty
	a_direct: assert property (p_direct) else $error("direct clock while multiplier runs");
	property p_lockrise; $rose(lockedOut) |-> $past(loopLockIn) && multiplierOn; endproperty
	a_lockrise: assert property (p_lockrise) else $error("lock without loop lock");
	property p_lockoff; !multiplierOn [*2] |-> !lockedOut; endproperty
	a_lockoff: assert property (p_lockoff) else $error("lock while multiplier off");
	property p_modtoggle; clkEn && modulatorClock |=> !modulatorClock; endproperty
	a_modtoggle: assert property (p_modtoggle) else $error("modulator clock high twice");
	property p_sleep; lvdsDriverOff |-> refPowerDown && clockPowerDown && chanPowerDown == 2'h3; endproperty
	a_sleep: assert property (p_sleep) else $error("sleep incomplete");
	property p_standby; clockPowerDown |-> chanPowerDown == 2'h3 ##1 (!clockPowerDown || !multiplierOn); endproperty
	a_standby: assert property (p_standby) else $error("standby incomplete");
	property p_sticky; serialActive |=> serialActive; endproperty
	a_sticky: assert property (p_sticky) else $error("serial mode dropped");
	property p_first; ok && clkEn && (regWrite || regRead) |=> serialActive; endproperty
	a_first: assert property (p_first) else $error("access left serial inactive");
	property p_rdlock; ok && clkEn && serialActive && !$past(regWrite) && regRead && regAddr == 8'h0a |=>
		regRdData[7] == $past(lockedOut); endproperty
	a_rdlock: assert property (p_rdlock) else $error("lock bit read wrong");
	property p_pin; pinMode && chanAPowerdownPin |=> chanPowerDown[0]; endproperty
	a_pin: assert property (p_pin) else $error("pin did not power down");
	property p_strapdir; (pinMode && factorStrapPins == 5'h1f) [*3] |-> directClock; endproperty
	a_strapdir: assert property (p_strapdir) else $error("strap 31 not direct");
	property p_strap42; (pinMode && factorStrapPins inside {[17:30]}) [*3] |-> multFactor == 6'h2a; endproperty
	a_strap42: assert property (p_strap42) else $error("upper strap not 42");
	property p_band; bandCalRun |-> autoBandSelect; endproperty
	a_band: assert property (p_band) else $error("band cal without select");
	c_lock: cover property ($rose(lockedOut));
	c_standby: cover property (clockPowerDown && !refPowerDown);
	c_sleep: cover property (lvdsDriverOff);
endmodule
bind pll_multiplier_power_mode_ctrl pll_ctrl_properties props (.clk(clk), .reset_n(reset_n), .clkEn(clkEn),
	.regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regRdData(regRdData),
	.factorStrapPins(factorStrapPins), .chanAPowerdownPin(chanAPowerdownPin), .loopLockIn(loopLockIn),
	.multFactor(multFactor), .multiplierOn(multiplierOn), .directClock(directClock),
	.autoBandSelect(autoBandSelect), .bandCalRun(bandCalRun), .lockedOut(lockedOut),
	.serialActive(serialActive), .modulatorClock(modulatorClock), .chanPowerDown(chanPowerDown),
	.clockPowerDown(clockPowerDown), .refPowerDown(refPowerDown), .lvdsDriverOff(lvdsDriverOff));
`default_nettype wire

// [sim/pll_multiplier_power_mode_ctrl_tb_top.sv]
// testbench for the multiplier and power mode block
// assumes the loop model as far side and short lock counts
`timescale 1ns/1ps
`default_nettype none
module pll_multiplier_power_mode_ctrl_tb_top;
	import pll_ctrl_pkg::*;
	logic       clk = 1'b0, reset_n = 1'b0, clkEn = 1'b1, regWrite = 1'b0, regRead = 1'b0;
	logic       chanAPd = 1'b0, chanBPd = 1'b0, loopLockIn, m;
	logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, d;
	logic [4:0] straps = 5'h1f;
	logic [5:0] multFactor;
	logic [1:0] chanPowerDown;
	logic       multiplierOn, directClock, autoBandSelect, bandCalRun, lockedOut, serialActive;
	logic       modulatorClock, clockPowerDown, refPowerDown, lvdsDriverOff;
	int         n_errors = 0, checks = 0, i;
	logic [7:0] modeExp [4] = '{8'h00, 8'h18, 8'h1c, 8'h1f};

	initial forever #2 clk = ~clk;

	pll_multiplier_power_mode_ctrl #(.BAND_CAL_CNT(4), .LOCK_QUAL_CNT(3)) dut (.clk(clk), .reset_n(reset_n),
		.clkEn(clkEn), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData),
		.regRdData(regRdData), .factorStrapPins(straps), .chanAPowerdownPin(chanAPd),
		.chanBPowerdownPin(chanBPd), .loopLockIn(loopLockIn), .multFactor(multFactor),
		.multiplierOn(multiplierOn), .directClock(directClock), .autoBandSelect(autoBandSelect),
		.bandCalRun(bandCalRun), .lockedOut(lockedOut), .serialActive(serialActive),
		.modulatorClock(modulatorClock), .chanPowerDown(chanPowerDown), .clockPowerDown(clockPowerDown),
		.refPowerDown(refPowerDown), .lvdsDriverOff(lvdsDriverOff));
	loop_lock_model #(.LOCK_DLY(5)) partner (.clk(clk), .run(multiplierOn && !bandCalRun),
		.lockDetect(loopLockIn));

	task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string msg);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk); regWrite <= 1'b1; regAddr <= a; regWrData <= v;
		@(posedge clk); regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk); regRead <= 1'b1; regAddr <= a;
		@(posedge clk); regRead <= 1'b0;
		#1 v = regRdData;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic waitLock;
		for (int k = 0; k < 300 && lockedOut !== 1'b1; k++) wt(1);
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	function automatic logic [7:0] strapN(int s);
		logic [7:0] t [17] = '{8, 9, 10, 12, 14, 15, 16, 17, 18, 20, 21, 24, 25, 28, 30, 32, 34};
		return (s < 17) ? t[s] : 8'd42;
	endfunction
	function automatic logic [7:0] regN(int c);
		if (c <= 8) return 8'd8;
		if (c <= 9) return 8'd9;
		if (c <= 11) return 8'd10;
		if (c <= 13) return 8'd12;
		if (c <= 17) return c[7:0];
		if (c <= 19) return 8'd18;
		if (c == 20) return 8'd20;
		if (c <= 23) return 8'd21;
		if (c == 24) return 8'd24;
		if (c <= 27) return 8'd25;
		if (c <= 29) return 8'd28;
		if (c <= 31) return 8'd30;
		if (c <= 33) return 8'd32;
		if (c <= 41) return 8'd34;
		return 8'd42;
	endfunction

	initial begin
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		wt(3);
		cmp({7'h0, directClock}, 8'h01, "default clocking");
		for (i = 0; i < 32; i++) begin
			@(posedge clk); straps <= i[4:0];
			wt(3);
			if (i == 31) cmp({7'h0, directClock}, 8'h01, "strap direct");
			else cmp({2'h0, multFactor}, strapN(i), "strap factor");
		end
		@(posedge clk); chanAPd <= 1'b1;
		wt(2);
		cmp({6'h0, chanPowerDown}, 8'h01, "pin a");
		@(posedge clk); chanAPd <= 1'b0; chanBPd <= 1'b1;
		wt(2);
		cmp({6'h0, chanPowerDown}, 8'h02, "pin b");
		cmp({7'h0, serialActive}, 8'h00, "serial idle");
		$display("test pins done");
		rd(8'h05, d);
		cmp({6'h0, d[1:0]}, 8'h03, "index reset");
		for (i = 0; i < 64; i++) begin
			wr(8'h0a, i[7:0]);
			wt(2);
			cmp({2'h0, multFactor}, regN(i), "register factor");
		end
		rd(8'h0a, d);
		cmp(d, 8'h3f, "lock bit while disabled");
		rd(8'h00, d);
		cmp(d, 8'h00, "unmapped");
		$display("test factor done");
		wr(8'h0a, 8'h6a);
		wr(8'h09, 8'h04);
		wt(1);
		cmp({6'h0, bandCalRun, multiplierOn}, 8'h03, "band cal running");
		waitLock();
		rd(8'h0a, d);
		cmp(d, 8'hea, "locked with autoband");
		wt(1);
		m = modulatorClock;
		wt(1);
		cmp({7'h0, modulatorClock}, {7'h0, ~m}, "modulator toggle");
		wr(8'h09, 8'h00);
		rd(8'h0a, d);
		cmp(d, 8'h6a, "lock clear on disable");
		wr(8'h0a, 8'h59);
		wr(8'h09, 8'h04);
		rd(8'h0a, d);
		cmp(d, 8'h59, "reacquire reads unlocked");
		waitLock();
		cmp({2'h0, multFactor}, 8'd25, "new factor");
		cmp({7'h0, lockedOut}, 8'h01, "relock");
		cmp({5'h0, multiplierOn, autoBandSelect, directClock}, 8'h06, "multiplier outputs");
		$display("test lock done");
		wr(8'h05, 8'h03);
		for (i = 0; i < 4; i++) begin
			wr(8'h08, i[7:0]);
			wt(2);
			cmp({3'h0, chanPowerDown, clockPowerDown, refPowerDown, lvdsDriverOff}, modeExp[i], "mode");
		end
		wr(8'h08, 8'h00);
		wr(8'h05, 8'h01);
		wr(8'h08, 8'h01);
		wt(2);
		cmp({6'h0, chanPowerDown}, 8'h01, "one channel");
		@(posedge clk);
		clkEn <= 1'b0;
		wr(8'h08, 8'h03);
		wt(2);
		cmp({6'h0, chanPowerDown}, 8'h01, "write ignored while frozen");
		@(posedge clk);
		clkEn <= 1'b1;
		$display("test power done");
		end_of_test();
	end

	initial begin
		repeat (6000) @(posedge clk);
		n_errors++;
		$display("mismatch at %0t: watchdog expired", $time);
		end_of_test();
	end
endmodule
`default_nettype wire
